// [common/flr_pkg.sv]
package flr_pkg;
  // link opcodes
  localparam logic [7:0] OP_IDLE = 8'h00;
  localparam logic [7:0] OP_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_UID = 8'h4B;
  localparam logic [7:0] OP_TABLE = 8'h5A;
  // bytes after the opcode before data, and the low address byte
  localparam logic [2:0] HDR_BYTES = 3'h4;
  localparam logic [2:0] ADDR_LOW_BYTE = 3'h3;
  localparam logic [11:0] LONG_HDR_BITS = 12'h028;
  localparam logic [11:0] CMD_BITS = 12'h008;
  // parameter table layout
  localparam logic [31:0] SIGNATURE = 32'h50444653;
  localparam logic [7:0] OFS_SIGNATURE = 8'h00;
  localparam logic [7:0] OFS_MINOR = 8'h04;
  localparam logic [7:0] OFS_MAJOR = 8'h05;
  localparam logic [7:0] OFS_HDR_COUNT = 8'h06;
  localparam logic [7:0] OFS_FILL_A = 8'h07;
  localparam logic [7:0] OFS_STD_ID = 8'h08;
  localparam logic [7:0] OFS_STD_MINOR = 8'h09;
  localparam logic [7:0] OFS_STD_MAJOR = 8'h0A;
  localparam logic [7:0] OFS_STD_LEN = 8'h0B;
  localparam logic [7:0] OFS_STD_PTR = 8'h0C;
  localparam logic [7:0] OFS_FILL_B = 8'h0F;
  localparam logic [7:0] OFS_VND_ID = 8'h10;
  localparam logic [7:0] OFS_VND_MINOR = 8'h11;
  localparam logic [7:0] OFS_VND_MAJOR = 8'h12;
  localparam logic [7:0] OFS_VND_LEN = 8'h13;
  localparam logic [7:0] OFS_VND_PTR = 8'h14;
  localparam logic [7:0] OFS_FILL_C = 8'h17;
  localparam logic [7:0] TABLE_MINOR = 8'h00;
  localparam logic [7:0] TABLE_MAJOR = 8'h01;
  localparam logic [7:0] HDR_COUNT = 8'h01;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] STD_ID = 8'h00;
  localparam logic [7:0] HDR_MINOR = 8'h00;
  localparam logic [7:0] HDR_MAJOR = 8'h01;
  localparam logic [7:0] STD_LEN = 8'h09;
  localparam logic [23:0] STD_PTR = 24'h000030;
  localparam logic [7:0] VND_LEN = 8'h03;
  localparam logic [23:0] VND_PTR = 24'h000060;
  // controller registers, byte addresses
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_LEN = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_RDATA = 5'h10;
  // timing
  localparam int MCLK_NS = 40;
  localparam logic [3:0] SCLK_HALF = 4'h4;
  localparam logic [15:0] CS_GAP_CYC = 16'h0004;
  localparam int T_RECOVERY_NS = 1000;
  localparam logic [15:0] RECOVERY_CYC =
    16'((T_RECOVERY_NS + MCLK_NS - 1) / MCLK_NS);
  typedef enum logic [1:0] {
    DS_CMD, DS_HDR, DS_DATA, DS_IGNORE
  } flr_dev_state_t;
  typedef enum logic [1:0] {
    HS_IDLE, HS_XFER, HS_GAP
  } flr_host_state_t;
endpackage

// [common/flr_link_if.sv]
`timescale 1ns/1ps
interface flr_link_if;
  logic sclk;
  logic csN;
  logic si;
  logic [2:0] sioUpper;
  logic so;
  logic soOeN;
  logic soLine;
  // pulled high while the device releases its output
  assign soLine = soOeN ? 1'b1 : so;
  modport device(input sclk, input csN, input si, input sioUpper,
                 output so, output soOeN);
  modport host(output sclk, output csN, output si, output sioUpper,
               input soLine);
endinterface

// [design/flr_table_rom.sv]
`timescale 1ns/1ps
module flr_table_rom #(
  parameter logic [7:0] VENDOR_ID = 8'hA5
) (
  input wire logic [7:0] addr,
  output logic [7:0] data
);
  always_comb begin
    data = flr_pkg::FILL_BYTE;
    if (addr < flr_pkg::OFS_MINOR) begin
      data = flr_pkg::SIGNATURE[{addr[1:0], 3'b000} +: 8];
    end else begin
      case (addr)
        flr_pkg::OFS_MINOR: data = flr_pkg::TABLE_MINOR;
        flr_pkg::OFS_MAJOR: data = flr_pkg::TABLE_MAJOR;
        flr_pkg::OFS_HDR_COUNT: data = flr_pkg::HDR_COUNT;
        flr_pkg::OFS_FILL_A: data = flr_pkg::FILL_BYTE;
        flr_pkg::OFS_STD_ID: data = flr_pkg::STD_ID;
        flr_pkg::OFS_STD_MINOR: data = flr_pkg::HDR_MINOR;
        flr_pkg::OFS_STD_MAJOR: data = flr_pkg::HDR_MAJOR;
        flr_pkg::OFS_STD_LEN: data = flr_pkg::STD_LEN;
        flr_pkg::OFS_STD_PTR: data = flr_pkg::STD_PTR[7:0];
        flr_pkg::OFS_STD_PTR + 8'h01: data = flr_pkg::STD_PTR[15:8];
        flr_pkg::OFS_STD_PTR + 8'h02: data = flr_pkg::STD_PTR[23:16];
        flr_pkg::OFS_FILL_B: data = flr_pkg::FILL_BYTE;
        flr_pkg::OFS_VND_ID: data = VENDOR_ID;
        flr_pkg::OFS_VND_MINOR: data = flr_pkg::HDR_MINOR;
        flr_pkg::OFS_VND_MAJOR: data = flr_pkg::HDR_MAJOR;
        flr_pkg::OFS_VND_LEN: data = flr_pkg::VND_LEN;
        flr_pkg::OFS_VND_PTR: data = flr_pkg::VND_PTR[7:0];
        flr_pkg::OFS_VND_PTR + 8'h01: data = flr_pkg::VND_PTR[15:8];
        flr_pkg::OFS_VND_PTR + 8'h02: data = flr_pkg::VND_PTR[23:16];
        flr_pkg::OFS_FILL_C: data = flr_pkg::FILL_BYTE;
        default: data = flr_pkg::FILL_BYTE;
      endcase
    end
  end
endmodule

// [design/flr_device_end.sv]
`timescale 1ns/1ps
// How it works
// - idle command only cancels a pending arm
// - idle command ignores upper serial lines
// - reset needs execute right after arm
// - reset clears all volatile state
// - any other command discards the arm
// - reset aborts running program or erase
// - reset commands ignore upper serial lines
// - fixed factory identifier, no command alters it
// - identifier read: opcode, four dummies, 128 bits
// - table read: opcode, three address, one dummy
// - chip select high stops output at once
// - only low address byte selects table byte
// - signature least byte first at 0..3
// - revisions zero and one, header count one
// - bytes 07h, 0Fh, 17h read all ones
// - standard header: nine words at 30h
// - vendor header: three words at 60h
module flr_device_end #(
  // arbitrary identifier values
  parameter logic [127:0] UNIQUE_ID =
    128'h0123456789ABCDEF_FEDCBA9876543210,
  parameter logic [7:0] VENDOR_ID = 8'hA5
) (
  flr_link_if.device link,
  input wire logic rst,
  input wire logic opBusy,
  output logic softReset,
  output logic abortOp,
  output logic armed
);
  flr_pkg::flr_dev_state_t state_reg;
  logic frameRst;
  logic [2:0] bitCnt_reg;
  logic [2:0] byteCnt_reg;
  logic [7:0] shiftIn_reg;
  logic [7:0] opcode_reg;
  logic [7:0] ptr_reg;
  logic [6:0] outShift_reg;
  logic so_reg;
  logic soOeN_reg;
  logic armed_reg;
  logic softReset_reg;
  logic abortOp_reg;
  logic [7:0] inByte;
  logic byteDone;
  logic cmdDone;
  logic fireReset;
  logic loadByte;
  logic [7:0] tableByte;
  logic [7:0] uidByte;
  logic [7:0] nextByte;

  // frame logic idles whenever chip select is high
  assign frameRst = rst | link.csN;

  // only the main serial input is sampled; upper lines never read
  assign inByte = {shiftIn_reg[6:0], link.si};
  assign byteDone = bitCnt_reg == 3'h7;
  assign cmdDone = state_reg == flr_pkg::DS_CMD && byteDone;
  assign fireReset = cmdDone && inByte == flr_pkg::OP_RESET &&
                     armed_reg;
  assign loadByte = byteDone &&
    ((state_reg == flr_pkg::DS_HDR &&
      byteCnt_reg == flr_pkg::HDR_BYTES) ||
     state_reg == flr_pkg::DS_DATA);

  flr_table_rom #(
    .VENDOR_ID(VENDOR_ID)
  ) uRom (
    .addr(ptr_reg),
    .data(tableByte)
  );

  // identifier is a parameter: no write path exists
  assign uidByte = UNIQUE_ID[{~ptr_reg[3:0], 3'b111} -: 8];
  assign nextByte = (opcode_reg == flr_pkg::OP_UID) ? uidByte :
                    tableByte;

  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      bitCnt_reg <= 3'h0;
    end else begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
    end
  end

  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      shiftIn_reg <= 8'h00;
    end else begin
      shiftIn_reg <= inByte;
    end
  end

  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      state_reg <= flr_pkg::DS_CMD;
      opcode_reg <= flr_pkg::OP_IDLE;
      byteCnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        flr_pkg::DS_CMD: begin
          if (byteDone) begin
            opcode_reg <= inByte;
            byteCnt_reg <= 3'h1;
            if (inByte == flr_pkg::OP_UID ||
                inByte == flr_pkg::OP_TABLE) begin
              state_reg <= flr_pkg::DS_HDR;
            end else begin
              // idle, arm, execute and others: rest of frame ignored
              state_reg <= flr_pkg::DS_IGNORE;
            end
          end
        end
        flr_pkg::DS_HDR: begin
          if (byteDone) begin
            if (byteCnt_reg == flr_pkg::HDR_BYTES) begin
              state_reg <= flr_pkg::DS_DATA;
            end else begin
              byteCnt_reg <= byteCnt_reg + 3'h1;
            end
          end
        end
        flr_pkg::DS_DATA: begin
          state_reg <= flr_pkg::DS_DATA;
        end
        flr_pkg::DS_IGNORE: begin
          state_reg <= flr_pkg::DS_IGNORE;
        end
        default: begin
          state_reg <= flr_pkg::DS_IGNORE;
        end
      endcase
    end
  end

  // read pointer: low address byte for the table, zero for the id
  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      ptr_reg <= 8'h00;
    end else if (cmdDone) begin
      ptr_reg <= 8'h00;
    end else if (state_reg == flr_pkg::DS_HDR && byteDone &&
                 byteCnt_reg == flr_pkg::ADDR_LOW_BYTE &&
                 opcode_reg == flr_pkg::OP_TABLE) begin
      ptr_reg <= inByte;
    end else if (loadByte) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // output shifter, new bit on each rising edge
  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      so_reg <= 1'b0;
      outShift_reg <= 7'h00;
    end else if (loadByte) begin
      so_reg <= nextByte[7];
      outShift_reg <= nextByte[6:0];
    end else if (state_reg == flr_pkg::DS_DATA) begin
      so_reg <= outShift_reg[6];
      outShift_reg <= {outShift_reg[5:0], 1'b0};
    end
  end

  // released asynchronously as chip select rises
  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      soOeN_reg <= 1'b1;
    end else if (loadByte) begin
      soOeN_reg <= 1'b0;
    end
  end

  // arm survives chip select; every decoded opcode rewrites it
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (cmdDone) begin
      armed_reg <= inByte == flr_pkg::OP_ARM;
    end
  end

  // pulses end at the next edge or when the frame closes
  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      softReset_reg <= 1'b0;
      abortOp_reg <= 1'b0;
    end else begin
      softReset_reg <= fireReset;
      abortOp_reg <= fireReset && opBusy;
    end
  end

  assign link.so = so_reg;
  assign link.soOeN = soOeN_reg;
  assign softReset = softReset_reg;
  assign abortOp = abortOp_reg;
  assign armed = armed_reg;
endmodule

// [design/flr_host_end.sv]
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module flr_host_end (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  flr_link_if.host link
);
  flr_pkg::flr_host_state_t state_reg;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [23:0] addr_reg;
  logic [7:0] len_reg;
  logic [7:0] opcode_reg;
  logic [2:0] upper_reg;
  logic [31:0] rx_reg;
  logic [39:0] tx_reg;
  logic [3:0] phase_reg;
  logic [11:0] bit_reg;
  logic [11:0] hdr_reg;
  logic [11:0] total_reg;
  logic [15:0] gap_reg;
  logic sclk_reg;
  logic csN_reg;
  logic si_reg;
  logic soMeta_reg;
  logic soSync_reg;
  logic [31:0] wmask;
  logic [31:0] cmdWord;
  logic accW;
  logic accR;
  logic start;
  logic isLong;

  genvar g;
  for (g = 0; g < 4; g++) begin : gLane
    assign wmask[8 * g +: 8] = {8{byteenable[g]}};
  end

  assign accW = write && !waitrequest_reg;
  // read data loaded in the wait cycle so it stands at the accept edge
  assign accR = read && waitrequest_reg;
  assign cmdWord = writedata & wmask;
  assign start = accW && address == flr_pkg::REG_CMD &&
                 byteenable[0] && state_reg == flr_pkg::HS_IDLE;
  assign isLong = cmdWord[7:0] == flr_pkg::OP_UID ||
                  cmdWord[7:0] == flr_pkg::OP_TABLE;

  // one wait cycle per access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= !((read || write) && waitrequest_reg);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_reg <= 24'h000000;
      len_reg <= 8'h00;
      opcode_reg <= flr_pkg::OP_IDLE;
      upper_reg <= 3'h0;
    end else if (accW) begin
      if (address == flr_pkg::REG_ADDR) begin
        addr_reg <= (addr_reg & ~wmask[23:0]) |
                    (writedata[23:0] & wmask[23:0]);
      end
      if (address == flr_pkg::REG_LEN && byteenable[0]) begin
        len_reg <= writedata[7:0];
      end
      if (start) begin
        opcode_reg <= cmdWord[7:0];
        upper_reg <= cmdWord[10:8];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readdata_reg <= 32'h00000000;
    end else if (accR) begin
      case (address)
        flr_pkg::REG_CMD: readdata_reg <= {21'h0, upper_reg, opcode_reg};
        flr_pkg::REG_ADDR: readdata_reg <= {8'h00, addr_reg};
        flr_pkg::REG_LEN: readdata_reg <= {24'h0, len_reg};
        flr_pkg::REG_STATUS: readdata_reg <=
          {30'h0, state_reg == flr_pkg::HS_GAP,
           state_reg != flr_pkg::HS_IDLE};
        flr_pkg::REG_RDATA: readdata_reg <= rx_reg;
        default: readdata_reg <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soMeta_reg <= 1'b1;
      soSync_reg <= 1'b1;
    end else begin
      soMeta_reg <= link.soLine;
      soSync_reg <= soMeta_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= flr_pkg::HS_IDLE;
      csN_reg <= 1'b1;
      sclk_reg <= 1'b0;
      si_reg <= 1'b0;
      tx_reg <= 40'h0;
      phase_reg <= 4'h0;
      bit_reg <= 12'h000;
      hdr_reg <= flr_pkg::CMD_BITS;
      total_reg <= flr_pkg::CMD_BITS;
      gap_reg <= 16'h0000;
    end else begin
      case (state_reg)
        flr_pkg::HS_IDLE: begin
          if (start) begin
            state_reg <= flr_pkg::HS_XFER;
            csN_reg <= 1'b0;
            phase_reg <= 4'h0;
            bit_reg <= 12'h000;
            if (isLong) begin
              tx_reg <= {cmdWord[7:0], addr_reg, 8'h00};
              hdr_reg <= flr_pkg::LONG_HDR_BITS;
              total_reg <= flr_pkg::LONG_HDR_BITS +
                           {1'b0, len_reg, 3'b000};
            end else begin
              tx_reg <= {cmdWord[7:0], 32'h0};
              hdr_reg <= flr_pkg::CMD_BITS;
              total_reg <= flr_pkg::CMD_BITS;
            end
          end
        end
        flr_pkg::HS_XFER: begin
          phase_reg <= (phase_reg == 2 * flr_pkg::SCLK_HALF - 4'h1) ?
                       4'h0 : phase_reg + 4'h1;
          if (phase_reg == 4'h0) begin
            sclk_reg <= 1'b0;
            si_reg <= tx_reg[39];
            tx_reg <= {tx_reg[38:0], 1'b0};
          end
          if (phase_reg == flr_pkg::SCLK_HALF) begin
            if (bit_reg == total_reg) begin
              csN_reg <= 1'b1;
              state_reg <= flr_pkg::HS_GAP;
              gap_reg <= (opcode_reg == flr_pkg::OP_RESET) ?
                flr_pkg::RECOVERY_CYC : flr_pkg::CS_GAP_CYC;
            end else begin
              sclk_reg <= 1'b1;
              bit_reg <= bit_reg + 12'h001;
            end
          end
        end
        flr_pkg::HS_GAP: begin
          if (gap_reg <= 16'h0001) begin
            state_reg <= flr_pkg::HS_IDLE;
          end
          gap_reg <= gap_reg - 16'h0001;
        end
        default: begin
          state_reg <= flr_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // data bit sampled just before the rising edge that follows it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_reg <= 32'h00000000;
    end else if (state_reg == flr_pkg::HS_XFER &&
                 phase_reg == flr_pkg::SCLK_HALF - 4'h1 &&
                 bit_reg >= hdr_reg && bit_reg < total_reg) begin
      rx_reg <= {rx_reg[30:0], soSync_reg};
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign link.sclk = sclk_reg;
  assign link.csN = csN_reg;
  assign link.si = si_reg;
  assign link.sioUpper = upper_reg;
endmodule

// [test/flr_link_checker.sv]
`timescale 1ns/1ps
module flr_link_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  input wire logic [2:0] sioUpper,
  input wire logic so,
  input wire logic soOeN,
  input wire logic soLine,
  input wire logic opBusy,
  input wire logic softReset,
  input wire logic abortOp,
  input wire logic armed
);
  logic [11:0] riseCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;

  // serial clock rises since chip select fell
  always_ff @(posedge sclk or posedge csN or posedge rst) begin
    if (rst || csN) begin
      riseCnt_reg <= 12'h000;
    end else if (riseCnt_reg != 12'hFFF) begin
      riseCnt_reg <= riseCnt_reg + 12'h001;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shift_reg <= 8'h00;
    end else begin
      shift_reg <= {shift_reg[6:0], si};
    end
  end

  // last decoded opcode, kept across frames
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      opcode_reg <= 8'h00;
    end else if (riseCnt_reg == 12'h007) begin
      opcode_reg <= {shift_reg[6:0], si};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_release_when_deselected: assert property (csN |-> soOeN)
    else $error("data out driven while deselected");
  a_output_after_header: assert property (
    !soOeN |-> riseCnt_reg >= flr_pkg::LONG_HDR_BITS)
    else $error("data out before header complete");
  a_output_only_reads: assert property (!soOeN |->
    (opcode_reg == flr_pkg::OP_UID || opcode_reg == flr_pkg::OP_TABLE))
    else $error("data out for a non-read command");
  a_data_moves_rise: assert property (
    $changed(so) && !soOeN && $past(!soOeN) |-> $rose(sclk))
    else $error("data out changed off a clock rise");
  a_reset_needs_arm: assert property ($rose(softReset) |->
    $past(armed) && opcode_reg == flr_pkg::OP_RESET)
    else $error("reset without a preceding arm");
  a_arm_follows_op: assert property (
    $rose(armed) |-> opcode_reg == flr_pkg::OP_ARM)
    else $error("arm set by another opcode");
  a_other_op_disarms: assert property (
    $changed(opcode_reg) && opcode_reg != flr_pkg::OP_ARM |-> !armed)
    else $error("arm kept after another opcode");
  a_reset_clears_arm: assert property (softReset |-> !armed)
    else $error("arm still set during reset");
  a_abort_with_reset: assert property (abortOp |-> softReset)
    else $error("abort without reset");
  a_abort_needs_busy: assert property (
    $rose(abortOp) |-> $past(opBusy))
    else $error("abort while no operation ran");
  a_pulse_ends_cs: assert property (csN |-> !softReset)
    else $error("reset pulse outlives the frame");
  a_upper_lines_steady: assert property (
    !csN && $past(!csN) |-> $stable(sioUpper))
    else $error("upper lines moved inside a frame");
endmodule

// [test/flash_reset_id_param_reader_test.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  nCompared++; \
  if ((got) !== (exp)) begin \
    errTotal++; \
    $display("BAD %0t got %h want %h", $time, (got), (exp)); \
  end \
end
module flash_reset_id_param_reader_test;
  // arbitrary identifier values
  localparam logic [127:0] UID = 128'hC3A51E7700FF9B2468ACE13579BDF024;
  localparam logic [7:0] VID = 8'h3C;
  // table bytes 00h..17h, vendor slot patched in want()
  localparam logic [191:0] TBL =
    192'h53464450_000101FF_00000109_300000FF_00000103_600000FF;
  localparam logic [63:0] STARTS = 64'h0004080C101416FE;
  localparam int LIMIT = 60000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic opBusy = 1'b0;
  logic softReset, abortOp, armed;
  int seed = 32'h9E32;
  int errTotal = 0;
  int nCompared = 0;
  int cycles = 0;
  int resets = 0;
  int aborts = 0;

  flr_link_if link();
  flr_host_end i_flr_host_end (.mclk(mclk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .link(link.host));
  flr_device_end #(.UNIQUE_ID(UID), .VENDOR_ID(VID)) i_flr_device_end (
    .link(link.device), .rst(rst), .opBusy(opBusy),
    .softReset(softReset), .abortOp(abortOp), .armed(armed));
  flr_link_checker i_flr_link_checker (.mclk(mclk), .rst(rst),
    .sclk(link.sclk), .csN(link.csN), .si(link.si),
    .sioUpper(link.sioUpper), .so(link.so), .soOeN(link.soOeN),
    .soLine(link.soLine), .opBusy(opBusy), .softReset(softReset),
    .abortOp(abortOp), .armed(armed));

  always #20 mclk = ~mclk;
  always @(posedge softReset) resets++;
  always @(posedge abortOp) aborts++;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errTotal++;
      $display("BAD %0t run timed out", $time);
      tally_and_finish();
    end
  end

  // last four bytes of an n-byte read, last byte lowest
  function automatic logic [31:0] want(input logic uidRd,
      input logic [7:0] a, input logic [7:0] n);
    logic [31:0] w;
    logic [7:0] b, i;
    w = 32'h0;
    for (int k = 0; k < 4; k++) begin
      i = a + n - 8'h04 + 8'(k);
      if (uidRd) b = UID[127 - 8 * int'(i[3:0]) -: 8];
      else if (i == 8'h10) b = VID;
      else if (i < 8'h18) b = TBL[191 - 8 * int'(i) -: 8];
      else b = 8'hFF;
      w = {w[23:0], b};
    end
    return w;
  endfunction

  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (waitrequest !== 1'b0 && t < 50);
    q = readdata;
    if (t >= 50) begin
      errTotal++;
      $display("BAD %0t bus stuck", $time);
    end
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] a,
      input logic [7:0] n);
    logic [31:0] q;
    int t;
    bus(1'b1, flr_pkg::REG_ADDR, {8'h00, a}, q);
    bus(1'b1, flr_pkg::REG_LEN, {24'h0, n}, q);
    // random upper line levels
    bus(1'b1, flr_pkg::REG_CMD, {21'h0, 3'($random(seed)), op}, q);
    t = 0;
    do begin
      bus(1'b0, flr_pkg::REG_STATUS, 32'h0, q);
      t++;
    end while (q[1:0] !== 2'b00 && t < 2000);
    if (t >= 2000) begin
      errTotal++;
      $display("BAD %0t frame stuck", $time);
    end
  endtask

  task automatic read_check(input logic u, input logic [7:0] a,
      input logic [7:0] n);
    logic [31:0] q;
    frame(u ? flr_pkg::OP_UID : flr_pkg::OP_TABLE,
      {16'($random(seed)), a}, n);
    bus(1'b0, flr_pkg::REG_RDATA, 32'h0, q);
    `CHK(q, want(u, a, n))
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] q;
    logic [7:0] a;
    int r0, a0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 14; k++) begin
      a = (k < 8) ? STARTS[63 - 8 * k -: 8] : 8'($random(seed) & 31);
      read_check(1'b0, a, 8'h04 + 8'($random(seed) & 7));
    end
    $display("table reads done");
    read_check(1'b1, 8'h00, 8'h04);
    read_check(1'b1, 8'h00, 8'h10);
    read_check(1'b1, 8'h00, 8'h14);
    $display("identifier reads done");
    for (int v = 0; v < 5; v++) begin
      r0 = resets;
      a0 = aborts;
      opBusy <= (v == 4);
      if (v != 3) begin
        frame(flr_pkg::OP_ARM, 24'h0, 8'h00);
        `CHK(armed, 1'b1)
      end
      if (v == 1) frame(flr_pkg::OP_IDLE, 24'h0, 8'h00);
      if (v == 2) frame(flr_pkg::OP_UID, 24'h0, 8'h04);
      if (v == 1 || v == 2) `CHK(armed, 1'b0)
      frame(flr_pkg::OP_RESET, 24'h0, 8'h00);
      `CHK(resets - r0, (v == 0 || v == 4) ? 1 : 0)
      `CHK(aborts - a0, (v == 4) ? 1 : 0)
      `CHK(armed, 1'b0)
    end
    opBusy <= 1'b0;
    $display("reset sequences done");
    read_check(1'b0, 8'h00, 8'h08);
    read_check(1'b1, 8'h00, 8'h10);
    bus(1'b0, 5'h14, 32'h0, q);
    `CHK(q, 32'h0)
    $display("after reset done");
    tally_and_finish();
  end
endmodule
